// file: inc/usb_sie_pkg.sv
// Notes on behaviour
// (R1) Select 1: PS/2 data low 128-256us interrupts.
// (R2) Select 0 default: SE0 128-256us gives reset.
// (R3) Firmware writes zero to status bit four.
// (R4) Engine sets sticky bus-activity bit on activity.
// (R5) Writing 0 clears activity bit; 1 keeps.
// (R6) Firmware polls and clears activity bit periodically.
// (R7) Codes 000-011: engine, K, J, SE0 drive.
// (R8) Codes 1xx drive lines open-drain low or release.
// (R9) Firmware selects 111 once before other open-drain codes.
// (R10) Hardware or bus reset clears address register.
// (R11) Respond only when enabled and address matches.
// (R12) Firmware programs host-assigned non-zero address.
// (R13) Control endpoint FIFO sits at 0xF8-0xFF.
// (R14) Data endpoint FIFO sits at 0xF0-0xF7.
// (R15) Engine update locks control mode until read.
// (R16) Firmware reads back mode after writing it.
// (R17) Unlocked write clears control mode bits 7-4.
// (R18) Setup flag forced high; CPU cannot clear.
// (R19) Setup flag blocks CPU control FIFO writes.
// (R20) IN/OUT flags set on transaction, cleared by write.
// (R21) Acked flag set on ACK-completed transaction.
// (R22) Mode 0001 NAKs IN/OUT, ACKs SETUP.
// (R23) Mode 1011 becomes 0001 after acked OUT.
// (R24) Data mode register: stall, read-clear acked, mode.
// (R25) Stall bit turns data endpoint ACK answers to IN/OUT into STALL; SETUP keeps ACK.
// (R26) Other modes come from external table, both endpoints.
package usb_sie_pkg;
  localparam int       ADDR_WIDTH         = 10;
  localparam logic [7:0] IDX_DEVICE_ADDRESS = 8'h10;
  localparam logic [7:0] IDX_CONTROL_MODE   = 8'h12;
  localparam logic [7:0] IDX_DATA_ONE_MODE  = 8'h14;
  localparam logic [7:0] IDX_LINE_STATUS    = 8'h1F;
  localparam logic [7:0] IDX_DATA_FIFO      = 8'hF0;
  localparam logic [7:0] IDX_CONTROL_FIFO   = 8'hF8;
  localparam int       ADDR_ENABLE_BIT    = 7;
  localparam int       SETUP_BIT          = 7;
  localparam int       IN_BIT             = 6;
  localparam int       OUT_BIT            = 5;
  localparam int       ACKED_BIT          = 4;
  localparam int       STALL_BIT          = 7;
  localparam int       PULLUP_BIT         = 7;
  localparam int       VREG_BIT           = 6;
  localparam int       INT_SELECT_BIT     = 5;
  localparam int       BUS_ACTIVITY_BIT   = 3;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [3:0] MODE_NAK_IN_OUT    = 4'h1;
  localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hB;
  localparam int       CLK_MHZ            = 250;
  localparam int       MIN_LOW_US         = 128;
  localparam int       MAX_LOW_US         = 256;
  localparam int       MIN_LOW_CYCLES     = MIN_LOW_US * CLK_MHZ;
  localparam int       MAX_LOW_CYCLES     = MAX_LOW_US * CLK_MHZ;
  localparam int       LOW_COUNT_WIDTH    = 17;
  typedef enum logic [3:0] {
    HS_NONE  = 4'b0001,
    HS_ACK   = 4'b0010,
    HS_NAK   = 4'b0100,
    HS_STALL = 4'b1000
  } handshake_type;
  typedef enum logic [2:0] {
    TOK_SETUP = 3'b001,
    TOK_IN    = 3'b010,
    TOK_OUT   = 3'b100
  } token_type;
  typedef enum logic [2:0] {
    LOW_IDLE  = 3'b001,
    LOW_COUNT = 3'b010,
    LOW_FIRED = 3'b100
  } low_state_type;
endpackage : usb_sie_pkg

// file: verilog/usb_sie_endpoint_control.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usb_sie_endpoint_control #(
  parameter int LowCycles = usb_sie_pkg::MIN_LOW_CYCLES
) (
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [usb_sie_pkg::ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           dPlusIn,
  input  wire logic                           dMinusIn,
  output logic                                dPlusOut,
  output logic                                dPlusOe,
  output logic                                dMinusOut,
  output logic                                dMinusOe,
  input  wire logic                           sieDPlus,
  input  wire logic                           sieDMinus,
  input  wire logic                           sieDriveEnable,
  input  wire logic                           busEvent,
  input  wire logic                           tokenValid,
  input  wire usb_sie_pkg::token_type         tokenKind,
  input  wire logic [6:0]                     tokenAddress,
  input  wire logic                           tokenEndpoint,
  output logic      [3:0]                     tableMode,
  input  wire usb_sie_pkg::handshake_type     tableHandshake,
  output usb_sie_pkg::handshake_type          handshake,
  output logic                                addressMatch,
  input  wire logic                           setupActive,
  input  wire logic                           controlInDone,
  input  wire logic                           controlOutDone,
  input  wire logic [1:0]                     endpointAcked,
  input  wire logic [1:0]                     endpointOutAcked,
  input  wire logic                           sieFifoWrite,
  input  wire logic [3:0]                     sieFifoIndex,
  input  wire logic [7:0]                     sieFifoData,
  output logic      [7:0]                     sieFifoReadData,
  output logic                                busResetIrq,
  output logic                                ps2ActivityIrq,
  output logic                                ps2PullupEnable,
  output logic                                regulatorEnable
);
  import usb_sie_pkg::*;

  initial begin
    if (LowCycles < 2 || LowCycles >= (1 << LOW_COUNT_WIDTH)) begin
      $error("LowCycles out of range");
    end
  end

  logic          rstMeta_q;
  logic          rstN;
  logic [7:0]    address_q;
  logic [7:0]    controlMode_q;
  logic [7:0]    dataMode_q;
  logic [7:0]    status_q;
  logic          controlLock_q;
  logic [7:0]    fifo_q [16];
  logic [31:0]   prdata_q;
  logic          pslverr_d;
  logic [7:0]    index;
  logic          apbWrite;
  logic          apbRead;
  logic          apbSetup;
  low_state_type lowState_q;
  logic [LOW_COUNT_WIDTH-1:0] lowCount_q;
  logic          lineLow;
  logic          lowFire;
  logic          busReset;
  logic          controlUpdate;
  logic          controlWrite;
  logic [3:0]    controlModeNext;
  handshake_type handshake_q;
  logic          dPlusOut_q;
  logic          dPlusOe_q;
  logic          dMinusOut_q;
  logic          dMinusOe_q;
  logic          busResetIrq_q;
  logic          ps2Irq_q;
  logic [7:0]    sieFifoReadData_q;

  // Async assert, synchronous release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  assign index    = paddr[9:2];
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign pready   = 1'b1;

  always_comb begin
    pslverr_d = 1'b1;
    if (index == IDX_DEVICE_ADDRESS || index == IDX_CONTROL_MODE ||
        index == IDX_DATA_ONE_MODE || index == IDX_LINE_STATUS ||
        index[7:4] == IDX_DATA_FIFO[7:4]) begin
      pslverr_d = 1'b0;
    end
  end
  assign pslverr = psel && penable && pslverr_d;

  // Read data is sampled in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      prdata_q <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata_q <= 32'h0000_0000;
      if (index == IDX_DEVICE_ADDRESS) begin
        prdata_q[7:0] <= address_q;
      end else if (index == IDX_CONTROL_MODE) begin
        prdata_q[7:0] <= controlMode_q;
      end else if (index == IDX_DATA_ONE_MODE) begin
        prdata_q[7:0] <= dataMode_q;
      end else if (index == IDX_LINE_STATUS) begin
        prdata_q[7:0] <= status_q;
      end else if (index[7:4] == IDX_DATA_FIFO[7:4]) begin
        prdata_q[7:0] <= fifo_q[index[3:0]];
      end
    end
  end
  assign prdata = prdata_q;

  // Status register; reserved bit 4 always reads zero (see R3)
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      status_q <= REG_RESET;
    end else begin
      if (apbWrite && index == IDX_LINE_STATUS) begin
        status_q[PULLUP_BIT]     <= pwdata[PULLUP_BIT];
        status_q[VREG_BIT]       <= pwdata[VREG_BIT];
        status_q[INT_SELECT_BIT] <= pwdata[INT_SELECT_BIT];
        status_q[2:0]            <= pwdata[2:0];
        if (!pwdata[BUS_ACTIVITY_BIT]) begin
          status_q[BUS_ACTIVITY_BIT] <= 1'b0; // see R5
        end
      end
      if (busEvent) begin
        status_q[BUS_ACTIVITY_BIT] <= 1'b1; // see R4
      end
    end
  end
  assign ps2PullupEnable = status_q[PULLUP_BIT];
  assign regulatorEnable = status_q[VREG_BIT];

  // Line forcing, registered so the pads see glitch-free levels
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      dPlusOut_q  <= 1'b0;
      dPlusOe_q   <= 1'b0;
      dMinusOut_q <= 1'b0;
      dMinusOe_q  <= 1'b0;
    end else begin
      case (status_q[2:0])
        3'h0: begin // see R7
          dPlusOut_q  <= sieDPlus;
          dMinusOut_q <= sieDMinus;
          dPlusOe_q   <= sieDriveEnable;
          dMinusOe_q  <= sieDriveEnable;
        end
        3'h1, 3'h2, 3'h3: begin // see R7
          dPlusOut_q  <= status_q[0] && !status_q[1];
          dMinusOut_q <= status_q[1] && !status_q[0];
          dPlusOe_q   <= 1'b1;
          dMinusOe_q  <= 1'b1;
        end
        default: begin // see R8
          dPlusOut_q  <= 1'b0;
          dMinusOut_q <= 1'b0;
          // Code bit 0 releases D+, code bit 1 releases D-
          dPlusOe_q   <= !status_q[0];
          dMinusOe_q  <= !status_q[1];
        end
      endcase
    end
  end
  assign dPlusOut  = dPlusOut_q;
  assign dPlusOe   = dPlusOe_q;
  assign dMinusOut = dMinusOut_q;
  assign dMinusOe  = dMinusOe_q;

  // Long-low detector; fires at the lower bound, just inside the window
  assign lineLow = status_q[INT_SELECT_BIT] ? !dMinusIn : (!dPlusIn && !dMinusIn);
  assign lowFire = (lowState_q == LOW_COUNT) && lineLow &&
                   (lowCount_q == LOW_COUNT_WIDTH'(LowCycles - 1));
  assign busReset = lowFire && !status_q[INT_SELECT_BIT];

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      lowState_q <= LOW_IDLE;
      lowCount_q <= '0;
    end else begin
      case (lowState_q)
        LOW_IDLE: begin
          lowCount_q <= '0;
          if (lineLow) begin
            lowState_q <= LOW_COUNT;
          end
        end
        LOW_COUNT: begin
          lowCount_q <= lowCount_q + 1'b1;
          if (!lineLow) begin
            lowState_q <= LOW_IDLE;
          end else if (lowFire) begin
            lowState_q <= LOW_FIRED;
          end
        end
        LOW_FIRED: begin
          if (!lineLow) begin
            lowState_q <= LOW_IDLE;
          end
        end
        default: lowState_q <= LOW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      busResetIrq_q <= 1'b0;
      ps2Irq_q      <= 1'b0;
    end else begin
      busResetIrq_q <= busReset;                            // see R2
      ps2Irq_q      <= lowFire && status_q[INT_SELECT_BIT]; // see R1
    end
  end
  assign busResetIrq    = busResetIrq_q;
  assign ps2ActivityIrq = ps2Irq_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      address_q <= REG_RESET;
    end else if (busReset) begin
      address_q <= REG_RESET; // see R10
    end else if (apbWrite && index == IDX_DEVICE_ADDRESS) begin
      address_q <= pwdata[7:0];
    end
  end
  assign addressMatch = address_q[ADDR_ENABLE_BIT] &&
                        (tokenAddress == address_q[6:0]); // see R11

  // Control endpoint mode with write lock
  assign controlUpdate = controlInDone || controlOutDone || endpointAcked[0] ||
                         (endpointOutAcked[0] && controlMode_q[3:0] == MODE_ACK_OUT_NAK_IN);
  assign controlWrite  = apbWrite && index == IDX_CONTROL_MODE && !controlLock_q;
  assign controlModeNext = (endpointOutAcked[0] && controlMode_q[3:0] == MODE_ACK_OUT_NAK_IN)
                         ? MODE_NAK_IN_OUT : controlMode_q[3:0]; // see R23

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      controlLock_q <= 1'b0;
    end else if (controlUpdate) begin
      controlLock_q <= 1'b1; // see R15
    end else if (apbRead && index == IDX_CONTROL_MODE) begin
      controlLock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      controlMode_q <= REG_RESET;
    end else begin
      if (controlWrite) begin
        controlMode_q <= {4'h0, pwdata[3:0]}; // see R17
      end else begin
        controlMode_q[3:0] <= controlModeNext;
      end
      if (setupActive) begin
        controlMode_q[SETUP_BIT] <= 1'b1; // see R18
      end
      if (controlInDone) begin
        controlMode_q[IN_BIT] <= 1'b1; // see R20
      end
      if (controlOutDone) begin
        controlMode_q[OUT_BIT] <= 1'b1; // see R20
      end
      if (endpointAcked[0]) begin
        controlMode_q[ACKED_BIT] <= 1'b1; // see R21
      end
    end
  end

  // Data endpoint mode: no lock, acked bit clears on read
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      dataMode_q <= REG_RESET;
    end else begin
      if (apbWrite && index == IDX_DATA_ONE_MODE) begin
        dataMode_q[STALL_BIT] <= pwdata[STALL_BIT]; // see R24
        dataMode_q[3:0]       <= pwdata[3:0];
      end else if (endpointOutAcked[1] && dataMode_q[3:0] == MODE_ACK_OUT_NAK_IN) begin
        dataMode_q[3:0] <= MODE_NAK_IN_OUT; // see R23
      end
      if (endpointAcked[1]) begin
        dataMode_q[ACKED_BIT] <= 1'b1; // see R21
      end else if (apbRead && index == IDX_DATA_ONE_MODE) begin
        dataMode_q[ACKED_BIT] <= 1'b0; // see R24
      end
    end
  end

  // Modes other than 0001 are resolved by the external table
  assign tableMode = tokenEndpoint ? dataMode_q[3:0] : controlMode_q[3:0]; // see R26

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      handshake_q <= HS_NONE;
    end else if (!(tokenValid && addressMatch)) begin
      handshake_q <= HS_NONE;
    end else if (tableMode == MODE_NAK_IN_OUT) begin
      handshake_q <= (tokenKind == TOK_SETUP) ? HS_ACK : HS_NAK; // see R22
    end else if (tokenEndpoint && dataMode_q[STALL_BIT] && tableHandshake == HS_ACK &&
                 tokenKind != TOK_SETUP) begin
      handshake_q <= HS_STALL; // see R25
    end else begin
      handshake_q <= tableHandshake; // see R26
    end
  end
  assign handshake = handshake_q;

  // Index 0-7 is the data endpoint FIFO, 8-15 the control endpoint FIFO
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < 16; i++) begin
        fifo_q[i] <= 8'h00;
      end
      sieFifoReadData_q <= 8'h00;
    end else begin
      sieFifoReadData_q <= fifo_q[sieFifoIndex];
      if (apbWrite && index[7:4] == IDX_DATA_FIFO[7:4] &&
          !(index[3] && controlMode_q[SETUP_BIT])) begin // see R13 see R14 see R19
        fifo_q[index[3:0]] <= pwdata[7:0];
      end
      if (sieFifoWrite) begin
        fifo_q[sieFifoIndex] <= sieFifoData;
      end
    end
  end
  assign sieFifoReadData = sieFifoReadData_q;

  sequence lowHeld_s;
    lineLow && lowState_q == LOW_IDLE ##1 lineLow [*8];
  endsequence

  sequence lowShort_s;
    lineLow && lowState_q == LOW_IDLE ##1 !lineLow;
  endsequence

  short_low_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R2
    lowShort_s |-> ##[1:2] !busResetIrq && !ps2ActivityIrq)
    else $error("interrupt after a one-cycle low");

  irq_timing_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R1
    $rose(busResetIrq || ps2ActivityIrq) |-> $past(lowState_q) == LOW_COUNT)
    else $error("interrupt without a counted low period");

  low_count_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R2
    lowHeld_s |-> lowState_q == LOW_COUNT || lowState_q == LOW_FIRED)
    else $error("low detector not counting");

  activity_sticky_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R4
    busEvent |=> status_q[BUS_ACTIVITY_BIT])
    else $error("bus activity not set");

  activity_keep_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R5
    status_q[BUS_ACTIVITY_BIT] && !(apbWrite && index == IDX_LINE_STATUS &&
    !pwdata[BUS_ACTIVITY_BIT]) |=> status_q[BUS_ACTIVITY_BIT])
    else $error("bus activity lost without a clear");

  force_k_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R7
    status_q[2:0] == 3'h1 |=> dPlusOut && !dMinusOut && dPlusOe && dMinusOe)
    else $error("forced K not driven");

  open_drain_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R8
    status_q[2] |=> !dPlusOut && !dMinusOut && dPlusOe == !$past(status_q[0]) &&
    dMinusOe == !$past(status_q[1]))
    else $error("open-drain forcing wrong");

  bus_reset_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R10
    busResetIrq |-> address_q == REG_RESET)
    else $error("address kept after bus reset");

  locked_write_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R15
    controlLock_q && apbWrite && index == IDX_CONTROL_MODE && !endpointOutAcked[0] &&
    !setupActive && !controlUpdate |=> $stable(controlMode_q))
    else $error("locked control mode was written");

  setup_hold_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R18
    setupActive |=> controlMode_q[SETUP_BIT])
    else $error("setup flag not held");

  nak_mode_a: assert property (@(posedge clk_sys) disable iff (!rstN) // see R22
    tokenValid && addressMatch && tableMode == MODE_NAK_IN_OUT && tokenKind == TOK_IN
    |=> handshake == HS_NAK)
    else $error("IN not NAKed in mode 0001");
endmodule : usb_sie_endpoint_control
`default_nettype wire

// file: bench/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] lineCmd,
  input  wire logic       dPlusOut,
  input  wire logic       dPlusOe,
  input  wire logic       dMinusOut,
  input  wire logic       dMinusOe,
  output logic            dPlusIn,
  output logic            dMinusIn
);
  logic hostPlus_q;
  logic hostMinus_q;
  // 0: idle J, 1: SE0 bus reset, 2: PS/2 host holding the data line low
  always_ff @(posedge clk_sys) begin
    hostPlus_q  <= (lineCmd == 2'h2);
    hostMinus_q <= (lineCmd == 2'h0);
  end
  // Device drive wins; the model never fights an enabled pad
  assign dPlusIn  = dPlusOe ? dPlusOut : hostPlus_q;
  assign dMinusIn = dMinusOe ? dMinusOut : hostMinus_q;
endmodule : usb_host_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module testbench;
  import usb_sie_pkg::*;
  localparam int LC = 20;
  typedef struct {string nm; logic [32:0] v;} note_type;
  note_type      notes[$];
  int            num_errors = 0;
  int            checks_done = 0;
  logic          clk_sys = 1'b0;
  logic          reset_n = 1'b0;
  logic          psel, penable, pwrite, pready, pslverr;
  logic [9:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic          dPlusIn, dMinusIn, dPlusOut, dPlusOe, dMinusOut, dMinusOe;
  logic          sieDPlus, sieDMinus, sieDriveEnable, busEvent, tokenValid;
  logic          tokenEndpoint, addressMatch, setupActive, controlInDone, controlOutDone;
  logic          sieFifoWrite, busResetIrq, ps2ActivityIrq, ps2PullupEnable, regulatorEnable;
  token_type     tokenKind;
  handshake_type tableHandshake, handshake;
  logic [6:0]    tokenAddress, addr;
  logic [3:0]    tableMode, sieFifoIndex;
  logic [1:0]    endpointAcked, endpointOutAcked, lineCmd;
  logic [7:0]    sieFifoData, sieFifoReadData, d1;
  logic          tokSeen = 1'b0;
  logic [2:0]    order [8] = '{0, 1, 2, 3, 7, 4, 5, 6};
  logic [3:0]    padTab [8] = '{4'h0, 4'hE, 4'hD, 4'hC, 4'hC, 4'h6, 4'h9, 4'h3};

  usb_sie_endpoint_control #(.LowCycles(LC)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dPlusIn(dPlusIn), .dMinusIn(dMinusIn), .dPlusOut(dPlusOut), .dPlusOe(dPlusOe),
    .dMinusOut(dMinusOut), .dMinusOe(dMinusOe), .sieDPlus(sieDPlus), .sieDMinus(sieDMinus),
    .sieDriveEnable(sieDriveEnable), .busEvent(busEvent), .tokenValid(tokenValid),
    .tokenKind(tokenKind), .tokenAddress(tokenAddress), .tokenEndpoint(tokenEndpoint),
    .tableMode(tableMode), .tableHandshake(tableHandshake), .handshake(handshake),
    .addressMatch(addressMatch), .setupActive(setupActive), .controlInDone(controlInDone),
    .controlOutDone(controlOutDone), .endpointAcked(endpointAcked),
    .endpointOutAcked(endpointOutAcked), .sieFifoWrite(sieFifoWrite),
    .sieFifoIndex(sieFifoIndex), .sieFifoData(sieFifoData), .sieFifoReadData(sieFifoReadData),
    .busResetIrq(busResetIrq), .ps2ActivityIrq(ps2ActivityIrq),
    .ps2PullupEnable(ps2PullupEnable), .regulatorEnable(regulatorEnable));

  usb_host_model i_host (
    .clk_sys(clk_sys), .lineCmd(lineCmd), .dPlusOut(dPlusOut), .dPlusOe(dPlusOe),
    .dMinusOut(dMinusOut), .dMinusOe(dMinusOe), .dPlusIn(dPlusIn), .dMinusIn(dMinusIn));

  always #2 clk_sys = ~clk_sys;

  // Results are matched in issue order; reads and tokens never overlap
  always @(posedge clk_sys) begin
    note_type n;
    if ((psel && penable && !pwrite && pready) || tokSeen) begin
      n = notes.pop_front();
      `CHK(n.nm, n.v, tokSeen ? {29'h0, handshake} : {pslverr, prdata})
    end
    tokSeen = tokenValid;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [32:0] e, input string nm);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!wr) notes.push_back('{nm, e});
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0, "");
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00, {25'h0, e}, nm);
  endtask : rd

  task automatic tok(input token_type k, input logic [6:0] a, input logic ep,
                     input handshake_type t, input handshake_type e);
    @(posedge clk_sys);
    tokenValid <= 1'b1;
    tokenKind <= k;
    tokenAddress <= a;
    tokenEndpoint <= ep;
    tableHandshake <= t;
    notes.push_back('{"handshake", {29'h0, e}});
    @(posedge clk_sys);
    tokenValid <= 1'b0;
  endtask : tok

  task automatic sie(input logic [6:0] p);
    @(posedge clk_sys);
    {busEvent, controlInDone, controlOutDone, endpointOutAcked, endpointAcked} <= p;
    @(posedge clk_sys);
    {busEvent, controlInDone, controlOutDone, endpointOutAcked, endpointAcked} <= 7'h00;
  endtask : sie

  task automatic waitIrq(input logic ps2);
    int   i;
    logic other;
    other = 1'b0;
    for (i = 0; i < 4 * LC; i++) begin
      @(posedge clk_sys);
      other |= ps2 ? busResetIrq : ps2ActivityIrq;
      if ((ps2 ? ps2ActivityIrq : busResetIrq) === 1'b1) break;
    end
    `CHK("irq_delay", 1'b1, i >= LC && i < 4 * LC)
    `CHK("other_irq", 1'b0, other)
    if (i == 4 * LC) final_report();
    lineCmd <= 2'h0;
  endtask : waitIrq

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, sieDPlus, sieDMinus, sieDriveEnable} = '0;
    {busEvent, tokenValid, tokenEndpoint, tokenAddress, setupActive, lineCmd} = '0;
    {controlInDone, controlOutDone, endpointAcked, endpointOutAcked} = '0;
    {sieFifoWrite, sieFifoIndex, sieFifoData} = '0;
    tokenKind = TOK_IN;
    tableHandshake = HS_NONE;
    void'($urandom(32'h494ca153));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(IDX_DEVICE_ADDRESS, 8'h00, "address");
    rd(IDX_CONTROL_MODE, 8'h00, "ctrl_mode");
    rd(IDX_DATA_ONE_MODE, 8'h00, "data_mode");
    rd(IDX_LINE_STATUS, 8'h00, "status");
    apb(1'b0, 8'h11, 8'h00, {1'b1, 32'h0}, "unmapped");
    sie(7'h40);
    rd(IDX_LINE_STATUS, 8'h08, "activity");
    wr(IDX_LINE_STATUS, 8'h08);
    rd(IDX_LINE_STATUS, 8'h08, "activity");
    wr(IDX_LINE_STATUS, 8'h00);
    rd(IDX_LINE_STATUS, 8'h00, "activity");
    $display("status test done");
    sieDriveEnable <= 1'b1;
    foreach (order[j]) begin
      sieDPlus <= 1'($urandom);
      sieDMinus <= 1'($urandom);
      wr(IDX_LINE_STATUS, {5'h00, order[j]});
      repeat (2) @(posedge clk_sys);
      `CHK("pads", order[j] == 3'h0 ? {2'b11, sieDPlus, sieDMinus} : padTab[order[j]], {dPlusOe, dMinusOe, dPlusOut | ~dPlusOe, dMinusOut | ~dMinusOe})
    end
    wr(IDX_LINE_STATUS, 8'h00);
    sieDriveEnable <= 1'b0;
    $display("forcing test done");
    addr = 7'($urandom_range(1, 127));
    wr(IDX_DEVICE_ADDRESS, {1'b1, addr});
    rd(IDX_DEVICE_ADDRESS, {1'b1, addr}, "address");
    wr(IDX_CONTROL_MODE, {4'h0, MODE_NAK_IN_OUT});
    tok(TOK_SETUP, addr, 1'b0, HS_STALL, HS_ACK);
    `CHK("match", 1'b1, addressMatch)
    tok(TOK_IN, addr, 1'b0, HS_ACK, HS_NAK);
    tok(TOK_OUT, addr, 1'b0, HS_ACK, HS_NAK);
    tok(TOK_IN, addr ^ 7'h01, 1'b0, HS_ACK, HS_NONE);
    wr(IDX_CONTROL_MODE, 8'h02);
    tok(TOK_IN, addr, 1'b0, HS_ACK, HS_ACK);
    `CHK("table_mode", 4'h2, tableMode)
    wr(IDX_CONTROL_MODE, 8'hFB);
    rd(IDX_CONTROL_MODE, 8'h0B, "ctrl_mode");
    sie(7'h15);
    wr(IDX_CONTROL_MODE, 8'h0F);
    rd(IDX_CONTROL_MODE, 8'h31, "ctrl_mode");
    wr(IDX_CONTROL_MODE, 8'h02);
    rd(IDX_CONTROL_MODE, 8'h02, "ctrl_mode");
    sie(7'h20);
    rd(IDX_CONTROL_MODE, 8'h42, "ctrl_mode");
    wr(IDX_DEVICE_ADDRESS, {1'b0, addr});
    tok(TOK_SETUP, addr, 1'b0, HS_ACK, HS_NONE);
    $display("control endpoint test done");
    d1 = 8'($urandom);
    wr(IDX_CONTROL_FIFO, d1);
    setupActive <= 1'b1;
    wr(IDX_CONTROL_FIFO, ~d1);
    rd(IDX_CONTROL_FIFO, d1, "ctrl_fifo");
    wr(IDX_CONTROL_MODE, 8'h00);
    rd(IDX_CONTROL_MODE, 8'h80, "ctrl_mode");
    setupActive <= 1'b0;
    wr(IDX_CONTROL_MODE, 8'h00);
    rd(IDX_CONTROL_MODE, 8'h00, "ctrl_mode");
    wr(IDX_CONTROL_FIFO + 8'h07, ~d1);
    sieFifoIndex <= 4'hF;
    repeat (2) @(posedge clk_sys);
    `CHK("sie_fifo", ~d1, sieFifoReadData)
    @(posedge clk_sys);
    sieFifoWrite <= 1'b1;
    sieFifoIndex <= 4'h3;
    sieFifoData <= d1;
    @(posedge clk_sys);
    sieFifoWrite <= 1'b0;
    rd(IDX_DATA_FIFO + 8'h03, d1, "data_fifo");
    $display("fifo test done");
    wr(IDX_DEVICE_ADDRESS, {1'b1, addr});
    wr(IDX_DATA_ONE_MODE, 8'h83);
    rd(IDX_DATA_ONE_MODE, 8'h83, "data_mode");
    tok(TOK_IN, addr, 1'b1, HS_ACK, HS_STALL);
    `CHK("table_mode", 4'h3, tableMode)
    sie(7'h02);
    rd(IDX_DATA_ONE_MODE, 8'h93, "data_mode");
    rd(IDX_DATA_ONE_MODE, 8'h83, "data_mode");
    $display("data endpoint test done");
    lineCmd <= 2'h1;
    waitIrq(1'b0);
    rd(IDX_DEVICE_ADDRESS, 8'h00, "address");
    wr(IDX_LINE_STATUS, 8'h20);
    lineCmd <= 2'h2;
    waitIrq(1'b1);
    $display("low detector test done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
